// ### hdl/rtt_ctrl.sv
// Functional notes
// - Hold program type code 0..31 and present it continuously.
// - Type name enable bit turns descriptive type name on or off.
// - Each radiotext buffer holds at most 64 characters.
// - Each radiotext buffer has its own include enable bit.
// - Switch period in minutes 0..255; zero means half a minute.
// - On expiry alternate texts, or step second-text messages when automatic.
// - Flag policy: fixed, first A second B, toggle on update, toggle plus override.
// - Restart bit set starts changed dynamic label at once when idle.
// - Changing the running dynamic label restarts it, except via enqueue.
// - Scroll speed bit selects high or low scrolling speed.
// - Static period sets idle units between dynamic label repeats.
// - Static period 255 shows dynamic label once per change only, with restart bit set.
// - With both dynamic labels enabled, static period is never zero.
// - Traffic flag is OR of switch and command sources.
// - Selecting another program set clears the traffic flag.
// - Timeout zero: switch is level sensitive, low means announcement.
// - Timeout 1..127: falling edge sets flag, clears after that many minutes.
// - Adding 128 lets a rising edge also clear before expiry.
// - Timeout counted on clock minute ticks only.
// - Other network one switch is level controlled only.
// - Traffic program flag zero forces timeout setting to zero.
// - Traffic label holds up to 8 characters; empty disables it.
`timescale 1ns/1ps
module rtt_ctrl
   import rtt_pkg::*;
#(
   parameter int unsigned HALF_MIN_CYC = HALF_MIN_CYCLES
)(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       cmd_valid,
   input  wire rtt_op_t    cmd_op,
   input  wire logic       cmd_sel,
   input  wire logic [5:0] cmd_addr,
   input  wire logic [7:0] cmd_data,
   input  wire logic       rt_rd_sel,
   input  wire logic [5:0] rt_rd_addr,
   input  wire logic [2:0] tps_rd_addr,
   input  wire logic       rtc_minute_tick,
   input  wire logic       static_unit_tick,
   input  wire logic       dps_end,
   input  wire logic       ta_switch_n,
   input  wire logic       other_network_one_traffic_n,
   output logic [4:0]      program_type,
   output logic            type_name_enable,
   output logic [1:0]      radiotext_enable,
   output logic            text_active_sel,
   output logic [6:0]      text_active_len,
   output logic            text_ab_flag,
   output logic            text_ab_override,
   output logic            second_text_message_step,
   output logic [7:0]      rt_rd_char,
   output logic            scroll_speed_select,
   output logic            label_running,
   output logic            label_which,
   output logic            label_start,
   output logic            label_restart,
   output logic            traffic_program,
   output logic            traffic_announce,
   output logic            other_network_one_ta,
   output logic            traffic_label_enable,
   output logic [7:0]      tps_rd_char
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  pty;
      logic        tn_en;
      logic [1:0]  rt_en;
      logic [6:0]  len0;
      logic [6:0]  len1;
      logic [7:0]  sw_per;
      logic [1:0]  policy;
      logic        restart;
      logic        scroll;
      logic [7:0]  sp_per;
      logic        ta_cmd;
      logic [7:0]  tmo;
      logic        tp;
      logic [3:0]  tps_len;
      logic        auto_msg;
      logic [1:0]  dps_en;
      logic        sel;
      logic        ab;
      logic        msg_step;
      logic [29:0] half_cnt;
      logic [8:0]  per_cnt;
      logic        run;
      logic        which;
      logic        pend;
      logic        pend_sel;
      logic [7:0]  st_cnt;
      logic        start;
      logic        rstrt;
      logic        prog_clr;
      logic        ta_out;
      logic        eon_ta;
   } rtt_st_t;

   rtt_st_t st_q;
   rtt_st_t st_d;

   // Text storage kept outside the struct to map onto RAM
   logic [7:0] rt_mem0 [RT_CHARS];
   logic [7:0] rt_mem1 [RT_CHARS];
   logic [7:0] tps_mem [TPS_CHARS];
   logic [7:0] rt_rd_q;
   logic [7:0] tps_rd_q;

   logic [1:0] sw_sync;
   logic       sw_ta;

   // ----------------------------------------------------------------
   // Switch inputs
   // ----------------------------------------------------------------
   // two-stage synchronisers
   rtt_sync #(.W(2)) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in ({other_network_one_traffic_n, ta_switch_n}),
      .sync_out (sw_sync)
   );

   rtt_ta_ctrl u_ta (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .sw_level    (sw_sync[0]),
      .timeout     (st_q.tmo),
      .minute_tick (rtc_minute_tick),
      .clear       (st_q.prog_clr),
      .sw_ta       (sw_ta)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic       wr;
   logic       half_tick;
   logic [8:0] per_tgt;
   logic       expire;
   logic [7:0] sp_eff;
   logic       nxt_sel;

   always_comb begin
      st_d          = st_q;
      wr            = cmd_valid;
      st_d.msg_step = 1'b0;
      st_d.start    = 1'b0;
      st_d.rstrt    = 1'b0;
      st_d.prog_clr = 1'b0;
      nxt_sel       = st_q.sel;

      if (wr) begin
         unique case (cmd_op)
            OP_PTY:           st_d.pty = cmd_data[4:0];
            OP_TYPE_NAME_EN:  st_d.tn_en = cmd_data[0];
            OP_RT_EN:         st_d.rt_en[cmd_sel] = cmd_data[0];
            OP_SWITCH_PERIOD: st_d.sw_per = cmd_data;
            OP_FLAG_POLICY:   st_d.policy = cmd_data[1:0];
            OP_RESTART:       st_d.restart = cmd_data[0];
            OP_SCROLL:        st_d.scroll = cmd_data[0];
            OP_STATIC_PERIOD: st_d.sp_per = cmd_data;
            OP_TA:            st_d.ta_cmd = cmd_data[0];
            OP_TIMEOUT:       st_d.tmo = cmd_data;
            OP_TP:            st_d.tp = cmd_data[0];
            OP_AUTO_MSG:      st_d.auto_msg = cmd_data[0];
            OP_DPS_EN:        st_d.dps_en = cmd_data[1:0];
            OP_RT_LEN: begin
               if (cmd_sel) begin
                  st_d.len1 = (cmd_data > 8'(RT_MAX_LEN)) ? RT_MAX_LEN : cmd_data[6:0];
               end else begin
                  st_d.len0 = (cmd_data > 8'(RT_MAX_LEN)) ? RT_MAX_LEN : cmd_data[6:0];
               end
               if (st_q.policy[1] && cmd_sel == st_q.sel) begin
                  st_d.ab = ~st_q.ab;
               end
            end
            OP_TPS_LEN: begin
               st_d.tps_len = (cmd_data > 8'(TPS_MAX_LEN)) ? TPS_MAX_LEN : cmd_data[3:0];
            end
            OP_PROGRAM: begin
               st_d.ta_cmd   = 1'b0;
               st_d.prog_clr = 1'b1;
            end
            OP_DPS_TEXT: begin
               if (st_q.run && st_q.which == cmd_sel && !cmd_data[1]) begin
                  st_d.rstrt = 1'b1;
               end else if (!st_q.run) begin
                  st_d.pend     = 1'b1;
                  st_d.pend_sel = cmd_sel;
               end
            end
            default: ;
         endcase
      end

      if (!st_d.tp) begin
         st_d.tmo = 8'h00;
      end

      // ------------------------------------------------------------
      // Radiotext switching
      // ------------------------------------------------------------
      half_tick = (st_q.half_cnt == 30'(HALF_MIN_CYC - 1));
      st_d.half_cnt = half_tick ? 30'h0 : st_q.half_cnt + 30'h1;
      per_tgt = (st_q.sw_per == 8'h00) ? 9'h001 : {st_q.sw_per, 1'b0};
      expire  = half_tick && (st_q.per_cnt + 9'h001 >= per_tgt);
      if (half_tick) begin
         st_d.per_cnt = expire ? 9'h000 : st_q.per_cnt + 9'h001;
      end

      if (st_q.rt_en == 2'b01) begin
         nxt_sel = 1'b0;
      end else if (st_q.rt_en == 2'b10) begin
         nxt_sel = 1'b1;
      end else if (expire && st_q.rt_en == 2'b11) begin
         nxt_sel = ~st_q.sel;
      end
      if (expire && st_q.auto_msg && st_q.rt_en[1] && (nxt_sel || !st_q.rt_en[0])) begin
         st_d.msg_step = 1'b1;
      end
      st_d.sel = nxt_sel;

      unique case (st_q.policy)
         POL_FIXED: st_d.ab = 1'b0;
         POL_SPLIT: st_d.ab = nxt_sel;
         default: begin
            if (expire && (nxt_sel != st_q.sel || st_d.msg_step)) begin
               st_d.ab = ~st_q.ab;
            end
         end
      endcase

      // ------------------------------------------------------------
      // Dynamic label sequencing
      // ------------------------------------------------------------
      // never zero with both enabled
      sp_eff = (st_q.dps_en == 2'b11 && st_q.sp_per == 8'h00) ? SP_MIN_BOTH : st_q.sp_per;
      if (st_q.run) begin
         if (dps_end) begin
            st_d.run    = 1'b0;
            st_d.st_cnt = 8'h00;
         end
      end else if (st_q.dps_en != 2'b00) begin
         if (st_q.pend && st_q.restart && st_q.dps_en[st_q.pend_sel]) begin
            st_d.run   = 1'b1;
            st_d.start = 1'b1;
            st_d.which = st_q.pend_sel;
            st_d.pend  = 1'b0;
         end else if (sp_eff != SP_ONCE && st_q.st_cnt >= sp_eff) begin
            st_d.run   = 1'b1;
            st_d.start = 1'b1;
            st_d.pend  = 1'b0;
            st_d.which = (st_q.dps_en == 2'b11) ? ~st_q.which : st_q.dps_en[1];
         end else if (static_unit_tick && st_q.st_cnt != 8'hFF) begin
            st_d.st_cnt = st_q.st_cnt + 8'h01;
         end
      end

      st_d.ta_out = (sw_ta || st_q.ta_cmd) && !st_q.prog_clr;
      st_d.eon_ta = ~sw_sync[1];
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q        <= '0;
         st_q.pty    <= RST_PTY;
         st_q.policy <= RST_POLICY;
         st_q.sw_per <= RST_SW_PERIOD;
         st_q.sp_per <= RST_SP_PERIOD;
         st_q.tmo    <= RST_TIMEOUT;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Text memories
   // ----------------------------------------------------------------
   // No reset on storage; lengths gate what is shown
   always_ff @(posedge sys_clk) begin
      if (wr && cmd_op == OP_RT_CHAR && !cmd_sel) begin
         rt_mem0[cmd_addr] <= cmd_data;
      end
      if (wr && cmd_op == OP_RT_CHAR && cmd_sel) begin
         rt_mem1[cmd_addr] <= cmd_data;
      end
      if (wr && cmd_op == OP_TPS_CHAR) begin
         tps_mem[cmd_addr[2:0]] <= cmd_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rt_rd_q  <= 8'h00;
         tps_rd_q <= 8'h00;
      end else begin
         rt_rd_q  <= rt_rd_sel ? rt_mem1[rt_rd_addr] : rt_mem0[rt_rd_addr];
         tps_rd_q <= tps_mem[tps_rd_addr];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign program_type             = st_q.pty;
   assign type_name_enable         = st_q.tn_en;
   assign radiotext_enable         = st_q.rt_en;
   assign text_active_sel          = st_q.sel;
   assign text_active_len          = st_q.sel ? st_q.len1 : st_q.len0;
   assign text_ab_flag             = st_q.ab;
   assign text_ab_override         = (st_q.policy == POL_OVERRIDE);
   assign second_text_message_step = st_q.msg_step;
   assign rt_rd_char               = rt_rd_q;
   assign scroll_speed_select      = st_q.scroll;
   assign label_running            = st_q.run;
   assign label_which              = st_q.which;
   assign label_start              = st_q.start;
   assign label_restart            = st_q.rstrt;
   assign traffic_program          = st_q.tp;
   assign traffic_announce         = st_q.ta_out;
   assign other_network_one_ta     = st_q.eon_ta;
   assign traffic_label_enable     = (st_q.tps_len != 4'h0);
   assign tps_rd_char              = tps_rd_q;

endmodule

// ### pkg/rtt_pkg.sv
package rtt_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned HALF_MINUTE_S   = 30;
   localparam int unsigned HALF_MIN_CYCLES = CLK_HZ * HALF_MINUTE_S;

   // ----------------------------------------------------------------
   // Sizes and limits
   // ----------------------------------------------------------------
   localparam int          RT_CHARS        = 64;
   localparam logic [6:0]  RT_MAX_LEN      = 7'h40;
   localparam int          TPS_CHARS       = 8;
   localparam logic [3:0]  TPS_MAX_LEN     = 4'h8;
   localparam logic [7:0]  SP_ONCE         = 8'hFF;
   localparam logic [7:0]  SP_MIN_BOTH     = 8'h01;
   localparam int          TMO_REL_BIT     = 7;

   // ----------------------------------------------------------------
   // Flag policy encodings
   // ----------------------------------------------------------------
   localparam logic [1:0]  POL_FIXED       = 2'h0;
   localparam logic [1:0]  POL_SPLIT       = 2'h1;
   localparam logic [1:0]  POL_TOGGLE      = 2'h2;
   localparam logic [1:0]  POL_OVERRIDE    = 2'h3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [4:0]  RST_PTY         = 5'h00;
   localparam logic [1:0]  RST_POLICY      = POL_TOGGLE;
   localparam logic [7:0]  RST_SW_PERIOD   = 8'h00;
   localparam logic [7:0]  RST_SP_PERIOD   = 8'h00;
   localparam logic [7:0]  RST_TIMEOUT     = 8'h00;

   // ----------------------------------------------------------------
   // Host commands
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP,
      OP_PTY,
      OP_TYPE_NAME_EN,
      OP_RT_CHAR,
      OP_RT_LEN,
      OP_RT_EN,
      OP_SWITCH_PERIOD,
      OP_FLAG_POLICY,
      OP_RESTART,
      OP_SCROLL,
      OP_STATIC_PERIOD,
      OP_TA,
      OP_TIMEOUT,
      OP_TP,
      OP_TPS_CHAR,
      OP_TPS_LEN,
      OP_PROGRAM,
      OP_DPS_EN,
      OP_AUTO_MSG,
      OP_DPS_TEXT
   } rtt_op_t;

endpackage

// ### hdl/rtt_sync.sv
`timescale 1ns/1ps
module rtt_sync
   import rtt_pkg::*;
#(
   parameter int W = 2
)(
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   // Reset to idle-high: an open switch input reads as released
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ### hdl/rtt_ta_ctrl.sv
`timescale 1ns/1ps
module rtt_ta_ctrl
   import rtt_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       sw_level,
   input  wire logic [7:0] timeout,
   input  wire logic       minute_tick,
   input  wire logic       clear,
   output logic            sw_ta
);

   typedef struct packed {
      logic       prev;
      logic       act;
      logic [6:0] mins;
   } rtt_ta_st_t;

   rtt_ta_st_t st_q;
   rtt_ta_st_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.prev = sw_level;
      if (timeout == 8'h00) begin
         st_d.act  = ~sw_level;
         st_d.mins = 7'h00;
      end else begin
         if (st_q.act && minute_tick && st_q.mins != 7'h00) begin
            st_d.mins = st_q.mins - 7'h01;
            if (st_q.mins == 7'h01) begin
               st_d.act = 1'b0;
            end
         end
         if (!st_q.prev && sw_level && timeout[TMO_REL_BIT]) begin
            st_d.act = 1'b0;
         end
         if (st_q.prev && !sw_level) begin
            st_d.act  = 1'b1;
            st_d.mins = timeout[6:0];
         end
      end
      if (clear) begin
         st_d.act = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '{prev: 1'b1, act: 1'b0, mins: 7'h00};
      end else begin
         st_q <= st_d;
      end
   end

   assign sw_ta = st_q.act;

endmodule

// ### test/rtt_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Traffic switches and minute clock
// ----------------------------------------
module rtt_far_model (
   input  wire logic sys_clk,
   input  wire logic ta_on,
   input  wire logic eon_on,
   input  wire logic tick_req,
   output logic      ta_switch_n,
   output logic      other_network_one_traffic_n,
   output logic      rtc_minute_tick = 1'b0
);
   logic tick_seen_q = 1'b0;

   // Open contacts float high through pull-ups
   assign ta_switch_n                 = !ta_on;
   assign other_network_one_traffic_n = !eon_on;

   // One pulse per toggle, so a slow bench never double counts
   always_ff @(posedge sys_clk) begin
      tick_seen_q     <= tick_req;
      rtc_minute_tick <= tick_req ^ tick_seen_q;
   end
endmodule

// ### test/rtt_ctrl_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module rtt_ctrl_monitor
   import rtt_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       cmd_valid,
   input wire rtt_op_t    cmd_op,
   input wire logic       cmd_sel,
   input wire logic [7:0] cmd_data,
   input wire logic       ta_switch_n,
   input wire logic       other_network_one_traffic_n,
   input wire logic [4:0] program_type,
   input wire logic       type_name_enable,
   input wire logic [1:0] radiotext_enable,
   input wire logic       text_ab_override,
   input wire logic       scroll_speed_select,
   input wire logic       label_running,
   input wire logic       label_which,
   input wire logic       label_restart,
   input wire logic       traffic_announce,
   input wire logic       other_network_one_ta,
   input wire logic       traffic_label_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_pty;
      cmd_valid && cmd_op == OP_PTY |=> program_type == $past(cmd_data[4:0]);
   endproperty
   a_pty: assert property (p_pty) else $error("program type wrong");
   property p_tne;
      cmd_valid && cmd_op == OP_TYPE_NAME_EN |=> type_name_enable == $past(cmd_data[0]);
   endproperty
   a_tne: assert property (p_tne) else $error("name enable wrong");
   property p_rten;
      cmd_valid && cmd_op == OP_RT_EN |=>
         radiotext_enable[$past(cmd_sel)] == $past(cmd_data[0]);
   endproperty
   a_rten: assert property (p_rten) else $error("text enable wrong");
   property p_ovr;
      cmd_valid && cmd_op == OP_FLAG_POLICY |=>
         text_ab_override == ($past(cmd_data[1:0]) == POL_OVERRIDE);
   endproperty
   a_ovr: assert property (p_ovr) else $error("override wrong");
   property p_scroll;
      cmd_valid && cmd_op == OP_SCROLL |=> scroll_speed_select == $past(cmd_data[0]);
   endproperty
   a_scroll: assert property (p_scroll) else $error("scroll wrong");
   property p_restart;
      cmd_valid && cmd_op == OP_DPS_TEXT && !cmd_data[1] && label_running
         && cmd_sel == label_which |=> label_restart;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");
   property p_prog;
      ta_switch_n[*4] ##0 (cmd_valid && cmd_op == OP_PROGRAM) |=> ##1 !traffic_announce;
   endproperty
   a_prog: assert property (p_prog) else $error("flag kept");
   property p_eon;
      (!other_network_one_traffic_n)[*5] |=> other_network_one_ta;
   endproperty
   a_eon: assert property (p_eon) else $error("other net flag low");
   property p_tle;
      cmd_valid && cmd_op == OP_TPS_LEN |=>
         traffic_label_enable == ($past(cmd_data) != 8'h00);
   endproperty
   a_tle: assert property (p_tle) else $error("label enable wrong");
endmodule

bind rtt_ctrl rtt_ctrl_monitor mon_u (
   .sys_clk, .rst, .cmd_valid, .cmd_op, .cmd_sel, .cmd_data, .ta_switch_n,
   .other_network_one_traffic_n, .program_type, .type_name_enable, .radiotext_enable,
   .text_ab_override, .scroll_speed_select, .label_running, .label_which,
   .label_restart, .traffic_announce, .other_network_one_ta, .traffic_label_enable
);

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import rtt_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam int HALF = 200;
   logic       sys_clk          = 1'b0;
   logic       rst              = 1'b1;
   logic       cmd_valid        = 1'b0;
   rtt_op_t    cmd_op           = OP_NOP;
   logic       cmd_sel          = 1'b0;
   logic [5:0] cmd_addr         = 6'h00;
   logic [7:0] cmd_data         = 8'h00;
   logic       rt_rd_sel        = 1'b0;
   logic [5:0] rt_rd_addr       = 6'h00;
   logic [2:0] tps_rd_addr      = 3'h0;
   logic       static_unit_tick = 1'b0;
   logic       dps_end          = 1'b0;
   logic       ta_on            = 1'b0;
   logic       eon_on           = 1'b0;
   logic       tick_req         = 1'b0;
   logic       rtc_minute_tick, ta_switch_n, other_network_one_traffic_n;
   logic [4:0] program_type;
   logic [1:0] radiotext_enable;
   logic [6:0] text_active_len;
   logic [7:0] rt_rd_char, tps_rd_char;
   logic       type_name_enable, text_active_sel, text_ab_flag, text_ab_override;
   logic       second_text_message_step, scroll_speed_select, label_running;
   logic       label_which, label_start, label_restart, traffic_program;
   logic       traffic_announce, other_network_one_ta, traffic_label_enable;
   logic       s;
   int         errors  = 0;
   int         checked = 0;
   int         starts  = 0;
   int         n;

   rtt_ctrl #(.HALF_MIN_CYC(HALF)) dut_u (
      .sys_clk, .rst, .cmd_valid, .cmd_op, .cmd_sel, .cmd_addr, .cmd_data, .rt_rd_sel,
      .rt_rd_addr, .tps_rd_addr, .rtc_minute_tick, .static_unit_tick, .dps_end,
      .ta_switch_n, .other_network_one_traffic_n, .program_type, .type_name_enable,
      .radiotext_enable, .text_active_sel, .text_active_len, .text_ab_flag,
      .text_ab_override, .second_text_message_step, .rt_rd_char, .scroll_speed_select,
      .label_running, .label_which, .label_start, .label_restart, .traffic_program,
      .traffic_announce, .other_network_one_ta, .traffic_label_enable, .tps_rd_char);
   rtt_far_model far_u (.sys_clk, .ta_on, .eon_on, .tick_req, .ta_switch_n,
      .other_network_one_traffic_n, .rtc_minute_tick);

   always #25 sys_clk = ~sys_clk;
   // Start pulses last one cycle, so count them as they pass
   always @(posedge sys_clk) if (label_start === 1'b1) starts <= starts + 1;

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic close_out;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask
   // Returns just after the taking edge, while pulses still stand
   task automatic cmd(input rtt_op_t op, input logic sel, input logic [5:0] a,
                      input logic [7:0] d);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_sel   <= sel;
      cmd_addr  <= a;
      cmd_data  <= d;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      #1;
   endtask
   task automatic pin(input logic v);
      @(posedge sys_clk);
      ta_on <= v;
      cyc(6);
   endtask
   task automatic tick;
      @(posedge sys_clk);
      tick_req <= !tick_req;
      cyc(6);
   endtask
   task automatic pulse(input logic fin);
      @(posedge sys_clk);
      if (fin) dps_end <= 1'b1;
      else static_unit_tick <= 1'b1;
      @(posedge sys_clk);
      dps_end          <= 1'b0;
      static_unit_tick <= 1'b0;
      cyc(3);
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(1);
      chk("override_rst", 8'(text_ab_override), 8'h00);
      cmd(OP_RT_CHAR, 1'b0, 6'h3F, 8'h5A);
      @(posedge sys_clk);
      rt_rd_addr  <= 6'h3F;
      tps_rd_addr <= 3'h7;
      cyc(2);
      chk("rt_char", rt_rd_char, 8'h5A);
      s = text_ab_flag;
      cmd(OP_RT_LEN, 1'b0, 6'h00, 8'h64);
      chk("rt_len", 8'(text_active_len), 8'h40);
      chk("ab_toggle", 8'(text_ab_flag), 8'(!s));
      for (int i = 0; i < 4; i++) begin
         cmd(OP_FLAG_POLICY, 1'b0, 6'h00, 8'(i));
         chk("override", 8'(text_ab_override), 8'(i == 3));
      end
      cmd(OP_FLAG_POLICY, 1'b0, 6'h00, 8'h00);
      s = text_ab_flag;
      cmd(OP_RT_LEN, 1'b0, 6'h00, 8'h10);
      chk("ab_fixed", 8'(text_ab_flag), 8'(s));
      cmd(OP_PTY, 1'b0, 6'h00, 8'h1F);
      chk("pty", 8'(program_type), 8'h1F);
      cmd(OP_TYPE_NAME_EN, 1'b0, 6'h00, 8'h01);
      chk("name_en", 8'(type_name_enable), 8'h01);
      cmd(OP_TYPE_NAME_EN, 1'b0, 6'h00, 8'h00);
      chk("name_dis", 8'(type_name_enable), 8'h00);
      cmd(OP_SCROLL, 1'b0, 6'h00, 8'h01);
      chk("scroll", 8'(scroll_speed_select), 8'h01);
      cmd(OP_TPS_CHAR, 1'b0, 6'h07, 8'h54);
      cyc(1);
      chk("tps_char", tps_rd_char, 8'h54);
      cmd(OP_TPS_LEN, 1'b0, 6'h00, 8'h08);
      chk("tps_on", 8'(traffic_label_enable), 8'h01);
      cmd(OP_TPS_LEN, 1'b0, 6'h00, 8'h00);
      chk("tps_off", 8'(traffic_label_enable), 8'h00);
      cmd(OP_RT_EN, 1'b1, 6'h00, 8'h01);
      cmd(OP_RT_EN, 1'b0, 6'h00, 8'h01);
      chk("rt_en", 8'(radiotext_enable), 8'h03);
      for (int k = 0; k < 2; k++) begin
         s = text_active_sel;
         n = 0;
         while (text_active_sel === s && n < 500) begin
            cyc(1);
            n++;
         end
      end
      chk("rt_period", 8'(n), 8'(HALF));
      // level mode, forced while no traffic program
      cmd(OP_TIMEOUT, 1'b0, 6'h00, 8'h02);
      @(posedge sys_clk);
      ta_on <= 1'b1;
      cyc(1);
      chk("sync", 8'(traffic_announce), 8'h00);
      cyc(5);
      chk("tmo_forced", 8'(traffic_announce), 8'h01);
      pin(1'b0);
      chk("lvl_off", 8'(traffic_announce), 8'h00);
      cmd(OP_TP, 1'b0, 6'h00, 8'h01);
      cmd(OP_TIMEOUT, 1'b0, 6'h00, 8'h00);
      pin(1'b1);
      chk("lvl_on", 8'(traffic_announce), 8'h01);
      pin(1'b0);
      cmd(OP_TA, 1'b0, 6'h00, 8'h01);
      pin(1'b1);
      pin(1'b0);
      chk("cmd_ta", 8'(traffic_announce), 8'h01);
      cmd(OP_PROGRAM, 1'b0, 6'h00, 8'h01);
      cyc(1);
      chk("prog_clr", 8'(traffic_announce), 8'h00);
      cmd(OP_TIMEOUT, 1'b0, 6'h00, 8'h02);
      pin(1'b1);
      pin(1'b0);
      chk("rise_ign", 8'(traffic_announce), 8'h01);
      tick();
      cyc(50);
      chk("one_min", 8'(traffic_announce), 8'h01);
      tick();
      chk("expired", 8'(traffic_announce), 8'h00);
      // rising edge clear, other network level
      cmd(OP_TIMEOUT, 1'b0, 6'h00, 8'h82);
      pin(1'b1);
      chk("edge_set", 8'(traffic_announce), 8'h01);
      pin(1'b0);
      chk("rise_clr", 8'(traffic_announce), 8'h00);
      @(posedge sys_clk);
      eon_on <= 1'b1;
      cyc(6);
      chk("eon_on", 8'(other_network_one_ta), 8'h01);
      @(posedge sys_clk);
      eon_on <= 1'b0;
      cyc(6);
      chk("eon_off", 8'(other_network_one_ta), 8'h00);
      cmd(OP_STATIC_PERIOD, 1'b0, 6'h00, 8'h02);
      cmd(OP_DPS_EN, 1'b0, 6'h00, 8'h01);
      n = starts;
      pulse(1'b0);
      chk("st_one", 8'(starts - n), 8'h00);
      pulse(1'b0);
      chk("st_two", 8'(starts - n), 8'h01);
      cmd(OP_STATIC_PERIOD, 1'b0, 6'h00, 8'hFF);
      cmd(OP_RESTART, 1'b0, 6'h00, 8'h01);
      pulse(1'b1);
      n = starts;
      cmd(OP_DPS_TEXT, 1'b0, 6'h00, 8'h00);
      cyc(3);
      chk("start", 8'(starts - n), 8'h01);
      cmd(OP_DPS_TEXT, 1'b0, 6'h00, 8'h00);
      chk("restart", 8'(label_restart), 8'h01);
      cmd(OP_DPS_TEXT, 1'b0, 6'h00, 8'h02);
      chk("enqueue", 8'(label_restart), 8'h00);
      close_out();
   end

   // Whole run is a few hundred cycles
   initial begin
      repeat (10000) @(posedge sys_clk);
      errors++;
      close_out();
   end
endmodule
